// *** common/gtm_map.vh ***
// Register map, field layouts, reset values and mode codes of the timer register block
`ifndef GTM_MAP_VH
`define GTM_MAP_VH
// Word offsets (byte addresses)
`define GTM_CFG_OFS        8'h00
`define GTM_MODE_A_OFS     8'h04
`define GTM_MODE_B_OFS     8'h08
`define GTM_CTL_OFS        8'h0c
`define GTM_INT_MASK_OFS   8'h18
`define GTM_INT_STAT_OFS   8'h1c
`define GTM_A_LOAD_OFS     8'h28
`define GTM_B_LOAD_OFS     8'h2c
`define GTM_A_MATCH_OFS    8'h30
`define GTM_B_MATCH_OFS    8'h34
`define GTM_A_PRE_OFS      8'h38
`define GTM_B_PRE_OFS      8'h3c
`define GTM_A_PMATCH_OFS   8'h40
`define GTM_B_PMATCH_OFS   8'h44
`define GTM_A_COUNT_OFS    8'h48
`define GTM_B_COUNT_OFS    8'h4c
// Reset values
`define GTM_HALF_ONES      16'hffff
`define GTM_HALF_ZERO      16'h0000
`define GTM_BYTE_ZERO      8'h00
// Width configuration codes (cfg bits 2:0)
`define GTM_CFG_32BIT      3'h0
`define GTM_CFG_32RTC      3'h1
`define GTM_CFG_16BIT      3'h4
// Per-half mode codes (mode bits 1:0)
`define GTM_MODE_PERIODIC  2'h0
`define GTM_MODE_PWM       2'h1
`define GTM_MODE_EDGE      2'h2
// Interrupt status bit positions
`define GTM_IRQ_A_TIMEOUT  0
`define GTM_IRQ_A_MATCH    1
`define GTM_IRQ_A_EDGE     2
`define GTM_IRQ_RTC        3
`define GTM_IRQ_B_TIMEOUT  8
`define GTM_IRQ_B_MATCH    9
`define GTM_IRQ_B_EDGE     10
`define GTM_IRQ_WIDTH      11
`endif

// *** hdl/gtm_half.v ***
// One 16-bit timer half with prescaler, match, PWM and edge counting
`timescale 1ns/1ns
`include "gtm_map.vh"
module gtm_half #(
    parameter CW = 16,                   // Counter width
    parameter PW = 8                     // Prescaler width
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst,
    // Control
    input  wire          run,            // Counting enabled
    input  wire [1:0]    mode,           // Periodic, PWM or edge count
    input  wire [CW-1:0] load_val,       // Interval load
    input  wire [CW-1:0] match_val,      // Match value
    input  wire [PW-1:0] pre_val,        // Prescale
    input  wire [PW-1:0] pmatch_val,     // Prescale match
    input  wire          edge_evt,       // Synchronised input edge pulse
    input  wire          tick_in,        // External tick (cascade), or 1
    // Status
    output reg  [CW-1:0] count,          // Live counter
    output reg  [CW-1:0] capture,        // Count at last edge
    output reg  [PW-1:0] pre_count,      // Live prescaler
    output reg           pwm_out,        // PWM output
    output reg           timeout_evt,    // Counter wrapped
    output reg           match_evt,      // 24-bit match event, or edge-count match in edge mode
    output reg           edge_seen       // Edge counted
);
    // Counter steps once the prescaler expires
    wire step   = run && tick_in && (pre_count == {PW{1'b0}});
    wire at_end = (count == {CW{1'b0}});
    wire edge_step = (mode == `GTM_MODE_EDGE) ? edge_evt : 1'b1;

    // Prescaler, counter and event logic
    always @(posedge core_clk) begin
        if (rst) begin
            count       <= `GTM_HALF_ONES;
            capture     <= `GTM_HALF_ONES;
            pre_count   <= `GTM_BYTE_ZERO;
            pwm_out     <= 1'b0;
            timeout_evt <= 1'b0;
            match_evt   <= 1'b0;
            edge_seen   <= 1'b0;
        end else begin
            timeout_evt <= 1'b0;
            match_evt   <= 1'b0;
            edge_seen   <= 1'b0;
            if (!run) begin
                pre_count <= pre_val;
                count     <= load_val;
            end else if (tick_in && edge_step) begin
                // Prescaler divides by pre_val + 1
                if (pre_count != {PW{1'b0}}) begin
                    pre_count <= pre_count - 1'b1;
                end else begin
                    pre_count <= pre_val;
                end
            end
            if (step && edge_step) begin
                if (mode == `GTM_MODE_EDGE) begin
                    // Counts load minus match edges, then reloads load_val and keeps counting
                    capture   <= count;
                    edge_seen <= 1'b1;
                    if (count == match_val + 1'b1) begin
                        match_evt <= 1'b1;
                        count     <= load_val;
                        pre_count <= pre_val;
                    end else begin
                        count <= count - 1'b1;
                    end
                end else if (at_end) begin
                    count       <= load_val;
                    timeout_evt <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
            // 24-bit match: counter above prescaler
            if (run && tick_in && mode != `GTM_MODE_EDGE && count == match_val
                && pre_count == pmatch_val) begin
                match_evt <= 1'b1;
            end
            // PWM high from reload down to match
            if (mode == `GTM_MODE_PWM) begin
                pwm_out <= run && (count > match_val);
            end else begin
                pwm_out <= 1'b0;
            end
        end
    end
endmodule // gtm_half

// *** hdl/gtm_regs.v ***
// Timer register block: load, match, prescale and count registers over Avalon-MM
// Behaviour
// - 32-bit config: B load ignores writes, reads count
// - 16-bit config: B load low field writable
// - B load, match, count reset to ffff
// - 32-bit RTC compares both match halves
// - 16-bit: A match high reads zero
// - PWM duty from match and load
// - Edge count counts load minus match
// - Match used only in RTC, PWM, edge
// - 8-bit prescale, reset zero, read back
// - 8-bit prescale match forms 24-bit compare
// - Count reads live, edge mode captured
// - A count high: B count or zero
// - Count registers read-only, reset ffff
// - 32-bit: A load high aliases B load
`timescale 1ns/1ns
`include "gtm_map.vh"
module gtm_regs #(
    parameter CW = 16,                        // Counter half width
    parameter PW = 8                          // Prescaler width
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst,
    // Avalon-MM slave
    input  wire [7:0]    avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [31:0]   avs_readdata,
    output wire          avs_waitrequest,
    // Edge capture pins
    input  wire          ccp_a_pin,
    input  wire          ccp_b_pin,
    // Outputs
    output wire          pwm_a,
    output wire          pwm_b,
    output wire          irq
);
    // Software state
    reg  [2:0]      cfg;                      // Width configuration
    reg  [1:0]      mode_a;                   // Timer A mode
    reg  [1:0]      mode_b;                   // Timer B mode
    reg  [1:0]      run;                      // Enables, bit0 A, bit1 B
    reg  [CW-1:0]   load_a;                   // Timer A load
    reg  [CW-1:0]   load_b;                   // Timer B load
    reg  [CW-1:0]   match_a;                  // Timer A match
    reg  [CW-1:0]   match_b;                  // Timer B match
    reg  [PW-1:0]   pre_a;                    // Timer A prescale
    reg  [PW-1:0]   pre_b;                    // Timer B prescale
    reg  [PW-1:0]   pmatch_a;                 // Timer A prescale match
    reg  [PW-1:0]   pmatch_b;                 // Timer B prescale match
    reg  [`GTM_IRQ_WIDTH-1:0] int_stat;       // Sticky status
    reg  [`GTM_IRQ_WIDTH-1:0] int_mask;       // Interrupt mask
    reg             ack;                      // One-cycle answer pulse
    // Pin synchronisers
    reg  [1:0]      ccp_a_s;                  // Pin A stages
    reg  [1:0]      ccp_b_s;                  // Pin B stages
    reg             ccp_a_d;                  // Pin A previous
    reg             ccp_b_d;                  // Pin B previous
    // Half outputs
    wire [CW-1:0]   cnt_a;                    // Live A count
    wire [CW-1:0]   cnt_b;                    // Live B count
    wire [CW-1:0]   cap_a;                    // A edge capture
    wire [CW-1:0]   cap_b;                    // B edge capture
    wire [PW-1:0]   pcnt_a;                   // A prescaler count
    wire [PW-1:0]   pcnt_b;                   // B prescaler count
    wire            to_a, to_b;               // Timeout pulses
    wire            mt_a, mt_b;               // Match pulses
    wire            ed_a, ed_b;               // Edge pulses
    wire            pwm_a_raw, pwm_b_raw;     // Half PWM outputs

    // Decoded configuration
    wire wide    = (cfg == `GTM_CFG_32BIT) || (cfg == `GTM_CFG_32RTC);
    wire rtc     = (cfg == `GTM_CFG_32RTC);
    wire [1:0] mode_a_eff = wide ? `GTM_MODE_PERIODIC : mode_a;
    wire [1:0] mode_b_eff = wide ? `GTM_MODE_PERIODIC : mode_b;
    wire edge_a  = ccp_a_s[1] & ~ccp_a_d;
    wire edge_b  = ccp_b_s[1] & ~ccp_b_d;
    // In 32-bit mode B counts when A wraps, forming one long counter
    wire b_tick  = wide ? (to_a || (cnt_a == {CW{1'b0}} && !run[0])) : 1'b1;
    wire do_wr   = avs_write && ack;      // Write lands on the answer edge
    wire do_rd   = avs_read && !ack;

    // Lane merge for byte-enabled writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[k*8 +: 8] = wd[k*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] wv_load_a  = merge({load_b, load_a}, avs_writedata, avs_byteenable);
    wire [31:0] wv_match_a = merge({match_b, match_a}, avs_writedata, avs_byteenable);
    wire [31:0] wv_load_b  = merge({16'h0000, load_b}, avs_writedata, avs_byteenable);
    wire [31:0] wv_match_b = merge({16'h0000, match_b}, avs_writedata, avs_byteenable);
    wire [31:0] wv_pre     = merge(32'h0000_0000, avs_writedata, avs_byteenable);

    // Whole 32-bit RTC match
    wire rtc_match = rtc && run[0] && ({cnt_b, cnt_a} == {match_b, match_a});
    // Match events counted only in the modes that use them
    wire use_a = rtc || (!wide && mode_a != `GTM_MODE_PERIODIC);
    wire use_b = !wide && mode_b != `GTM_MODE_PERIODIC;

    // Event vector for the sticky status
    wire [`GTM_IRQ_WIDTH-1:0] events;
    assign events[`GTM_IRQ_A_TIMEOUT] = to_a;
    assign events[`GTM_IRQ_A_MATCH]   = mt_a && use_a && !rtc;
    assign events[`GTM_IRQ_A_EDGE]    = ed_a;
    assign events[`GTM_IRQ_RTC]       = rtc_match;
    assign events[7:4]                = 4'h0;
    assign events[`GTM_IRQ_B_TIMEOUT] = to_b && !wide;
    assign events[`GTM_IRQ_B_MATCH]   = mt_b && use_b;
    assign events[`GTM_IRQ_B_EDGE]    = ed_b && !wide;

    // Bus handshake: one wait cycle then answer
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign irq   = |(int_stat & int_mask);
    assign pwm_a = pwm_a_raw;
    assign pwm_b = pwm_b_raw;

    // Synchronise capture pins
    always @(posedge core_clk) begin
        if (rst) begin
            ccp_a_s <= 2'b00;
            ccp_b_s <= 2'b00;
            ccp_a_d <= 1'b0;
            ccp_b_d <= 1'b0;
        end else begin
            ccp_a_s <= {ccp_a_s[0], ccp_a_pin};
            ccp_b_s <= {ccp_b_s[0], ccp_b_pin};
            ccp_a_d <= ccp_a_s[1];
            ccp_b_d <= ccp_b_s[1];
        end
    end

    // Register writes and status
    always @(posedge core_clk) begin
        if (rst) begin
            cfg      <= `GTM_CFG_32BIT;
            mode_a   <= `GTM_MODE_PERIODIC;
            mode_b   <= `GTM_MODE_PERIODIC;
            run      <= 2'b00;
            load_a   <= `GTM_HALF_ONES;
            load_b   <= `GTM_HALF_ONES;
            match_a  <= `GTM_HALF_ONES;
            match_b  <= `GTM_HALF_ONES;
            pre_a    <= `GTM_BYTE_ZERO;
            pre_b    <= `GTM_BYTE_ZERO;
            pmatch_a <= `GTM_BYTE_ZERO;
            pmatch_b <= `GTM_BYTE_ZERO;
            int_stat <= {`GTM_IRQ_WIDTH{1'b0}};
            int_mask <= {`GTM_IRQ_WIDTH{1'b0}};
            ack      <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
            // Set wins over write-one-to-clear
            if (do_wr && avs_address == `GTM_INT_STAT_OFS) begin
                int_stat <= (int_stat & ~avs_writedata[`GTM_IRQ_WIDTH-1:0]) | events;
            end else begin
                int_stat <= int_stat | events;
            end
            if (do_wr) begin
                case (avs_address)
                    `GTM_CFG_OFS:      cfg    <= avs_writedata[2:0];
                    `GTM_MODE_A_OFS:   mode_a <= avs_writedata[1:0];
                    `GTM_MODE_B_OFS:   mode_b <= avs_writedata[1:0];
                    `GTM_CTL_OFS:      run    <= avs_writedata[1:0];
                    `GTM_INT_MASK_OFS: int_mask <= avs_writedata[`GTM_IRQ_WIDTH-1:0];
                    `GTM_A_LOAD_OFS: begin
                        load_a <= wv_load_a[15:0];
                        if (wide) begin
                            load_b <= wv_load_a[31:16];
                        end
                    end
                    `GTM_B_LOAD_OFS: begin
                        if (!wide) begin
                            load_b <= wv_load_b[15:0];
                        end
                    end
                    `GTM_A_MATCH_OFS: begin
                        match_a <= wv_match_a[15:0];
                        if (wide) begin
                            match_b <= wv_match_a[31:16];
                        end
                    end
                    `GTM_B_MATCH_OFS:  match_b  <= wv_match_b[15:0];
                    `GTM_A_PRE_OFS:    pre_a    <= wv_pre[7:0];
                    `GTM_B_PRE_OFS:    pre_b    <= wv_pre[7:0];
                    `GTM_A_PMATCH_OFS: pmatch_a <= wv_pre[7:0];
                    `GTM_B_PMATCH_OFS: pmatch_b <= wv_pre[7:0];
                    default: ;                     // Count registers are read-only
                endcase
            end
        end
    end

    // Read data register; unmapped reads give zero
    always @(posedge core_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (do_rd) begin
            case (avs_address)
                `GTM_CFG_OFS:      avs_readdata <= {29'h0, cfg};
                `GTM_MODE_A_OFS:   avs_readdata <= {30'h0, mode_a};
                `GTM_MODE_B_OFS:   avs_readdata <= {30'h0, mode_b};
                `GTM_CTL_OFS:      avs_readdata <= {30'h0, run};
                `GTM_INT_MASK_OFS: avs_readdata <= {21'h0, int_mask};
                `GTM_INT_STAT_OFS: avs_readdata <= {21'h0, int_stat};
                `GTM_A_LOAD_OFS:
                    avs_readdata <= {(wide ? load_b : `GTM_HALF_ZERO), load_a};
                `GTM_B_LOAD_OFS:
                    avs_readdata <= {16'h0, (wide ? cnt_b : load_b)};
                `GTM_A_MATCH_OFS:
                    avs_readdata <= {(wide ? match_b : `GTM_HALF_ZERO), match_a};
                `GTM_B_MATCH_OFS:  avs_readdata <= {16'h0, match_b};
                `GTM_A_PRE_OFS:    avs_readdata <= {24'h0, pre_a};
                `GTM_B_PRE_OFS:    avs_readdata <= {24'h0, pre_b};
                `GTM_A_PMATCH_OFS: avs_readdata <= {24'h0, pmatch_a};
                `GTM_B_PMATCH_OFS: avs_readdata <= {24'h0, pmatch_b};
                `GTM_A_COUNT_OFS:
                    avs_readdata <= {(wide ? cnt_b : `GTM_HALF_ZERO),
                        (mode_a_eff == `GTM_MODE_EDGE ? cap_a : cnt_a)};
                `GTM_B_COUNT_OFS:
                    avs_readdata <= {16'h0,
                        (mode_b_eff == `GTM_MODE_EDGE ? cap_b : cnt_b)};
                default:           avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Timer A half
    gtm_half #(.CW(CW), .PW(PW)) u_half_a (
        .core_clk    (core_clk),
        .rst         (rst),
        .run         (run[0]),
        .mode        (mode_a_eff),
        .load_val    (load_a),
        .match_val   (match_a),
        .pre_val     (wide ? `GTM_BYTE_ZERO : pre_a),
        .pmatch_val  (wide ? `GTM_BYTE_ZERO : pmatch_a),
        .edge_evt    (edge_a),
        .tick_in     (1'b1),
        .count       (cnt_a),
        .capture     (cap_a),
        .pre_count   (pcnt_a),
        .pwm_out     (pwm_a_raw),
        .timeout_evt (to_a),
        .match_evt   (mt_a),
        .edge_seen   (ed_a)
    );

    // Timer B half; upper half of the 32-bit counter when wide
    gtm_half #(.CW(CW), .PW(PW)) u_half_b (
        .core_clk    (core_clk),
        .rst         (rst),
        .run         (wide ? run[0] : run[1]),
        .mode        (mode_b_eff),
        .load_val    (load_b),
        .match_val   (match_b),
        .pre_val     (wide ? `GTM_BYTE_ZERO : pre_b),
        .pmatch_val  (wide ? `GTM_BYTE_ZERO : pmatch_b),
        .edge_evt    (edge_b),
        .tick_in     (b_tick),
        .count       (cnt_b),
        .capture     (cap_b),
        .pre_count   (pcnt_b),
        .pwm_out     (pwm_b_raw),
        .timeout_evt (to_b),
        .match_evt   (mt_b),
        .edge_seen   (ed_b)
    );
endmodule // gtm_regs

// *** sim/gtm_regs_checker.sv ***
// Port-level assertions for the timer register block
`timescale 1ns/1ns
module gtm_regs_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Avalon-MM slave side
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins and outputs
    input wire logic        ccp_a_pin,
    input wire logic        ccp_b_pin,
    input wire logic        pwm_a,
    input wire logic        pwm_b,
    input wire logic        irq
);
    logic rd_pend;  // A read was waiting last cycle
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Track cycles where the read answer gets loaded
    always @(posedge core_clk) begin
        rd_pend <= rst ? 1'b0 : (avs_read && avs_waitrequest);
    end

    // First cycle of a request always waits
    a_wait_first_cycle: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("no wait state on a new request");
    // Exactly one wait state, then the answer
    a_wait_one_only: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("answer not given after one wait");
    // No wait signalled while idle
    a_wait_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    // Read data holds between answers
    a_read_data_holds: assert property (!rd_pend |-> $stable(avs_readdata))
        else $error("read data changed outside an answer");
    // Unmapped space above 0x4c reads zero
    a_unmapped_reads_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h4c
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    // Prescale fields are eight bits wide
    a_prescale_eight_bits: assert property (
        avs_read && !avs_waitrequest && avs_address >= 8'h38
        && avs_address <= 8'h44 |-> avs_readdata[31:8] == 24'h0)
        else $error("prescale upper bits not zero");
    // Timer B registers hold sixteen bits
    a_b_upper_zero: assert property (
        avs_read && !avs_waitrequest && (avs_address == 8'h2c
        || avs_address == 8'h34 || avs_address == 8'h4c) |-> avs_readdata[31:16] == 16'h0)
        else $error("timer B register upper half not zero");
    // Outputs quiet straight after reset
    a_reset_outputs_quiet: assert property ($fell(rst) |-> !irq && !pwm_a && !pwm_b)
        else $error("irq or pwm active after reset");
endmodule // gtm_regs_checker

// *** sim/gtm_regs_tb.sv ***
// Self-checking bench for the timer register block
`timescale 1ns/1ns
module gtm_regs_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} gtm_row_t;
    logic        core_clk = 1'b0;       // 25 MHz clock
    logic        rst = 1'b1;            // Sync reset
    logic [7:0]  avs_address = 8'h0;    // Bus address
    logic        avs_read = 1'b0;       // Read request
    logic        avs_write = 1'b0;      // Write request
    logic [31:0] avs_writedata = 32'h0; // Write data
    logic [3:0]  avs_byteenable = 4'hf; // All lanes
    logic [31:0] avs_readdata;          // Read data
    logic        avs_waitrequest;       // Wait flag
    logic        ccp_a_pin = 1'b0;      // Edge input A
    logic        ccp_b_pin = 1'b0;      // Edge input B
    logic        pwm_a, pwm_b, irq;     // Outputs
    int          mismatches = 0;        // Failed compares
    int          checked = 0;           // All compares
    logic [31:0] q;                     // Last read data
    int          hi;                    // PWM high cycles
    // Ordinary cases: write flag, address, data, expected read
    gtm_row_t rows [0:23] = '{
        '{1'b0, 8'h2c, 32'h0, 32'h0000ffff},
        '{1'b0, 8'h34, 32'h0, 32'h0000ffff},
        '{1'b0, 8'h38, 32'h0, 32'h0}, '{1'b0, 8'h3c, 32'h0, 32'h0},
        '{1'b0, 8'h40, 32'h0, 32'h0}, '{1'b0, 8'h44, 32'h0, 32'h0},
        '{1'b0, 8'h48, 32'h0, 32'hffffffff},
        '{1'b0, 8'h4c, 32'h0, 32'h0000ffff},
        '{1'b0, 8'h50, 32'h0, 32'h0},            // Unmapped
        '{1'b1, 8'h00, 32'h4, 32'h4},            // Sixteen-bit config
        '{1'b1, 8'h38, 32'ha5, 32'ha5}, '{1'b1, 8'h3c, 32'h5a, 32'h5a},
        '{1'b1, 8'h40, 32'hc3, 32'hc3}, '{1'b1, 8'h44, 32'h3c, 32'h3c},
        '{1'b1, 8'h2c, 32'h1234, 32'h1234},
        '{1'b1, 8'h34, 32'h0567, 32'h0567},      // Timer B match
        '{1'b1, 8'h30, 32'habcd0042, 32'h42},
        '{1'b0, 8'h34, 32'h0, 32'h0567},
        '{1'b1, 8'h4c, 32'h0, 32'h1234},
        '{1'b1, 8'h00, 32'h0, 32'h0},            // Wide config
        '{1'b1, 8'h2c, 32'h5555, 32'h1234},
        '{1'b1, 8'h28, 32'h77770011, 32'h77770011},
        '{1'b0, 8'h2c, 32'h0, 32'h7777},
        '{1'b0, 8'h48, 32'h0, 32'h77770011}};

    gtm_regs u_dut (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ccp_a_pin(ccp_a_pin), .ccp_b_pin(ccp_b_pin), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));

    // Clock generator
    always #20 core_clk = ~core_clk;

    // Verdict and end of run
    task complete_run;
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon-MM access, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            complete_run();
        end else begin
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    // Wait for a rising pwm_b, counting cycles in hi
    task rise;
        while (pwm_b !== 1'b0 && hi < 200) begin
            @(negedge core_clk);
            hi++;
        end
        while (pwm_b !== 1'b1 && hi < 200) begin
            @(negedge core_clk);
            hi++;
        end
        if (hi >= 200) begin
            mismatches++;
            complete_run();
        end
    endtask

    // Rising edges on capture pin A
    task edges(input int n);
        repeat (n) begin
            @(posedge core_clk) ccp_a_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            ccp_a_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // Table of plain accesses
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk("row read", rows[i].e, q);
        end
        bus(1'b1, 8'h00, 32'h4);
        bus(1'b0, 8'h48, 32'h0);
        chk("A count high in narrow config", 32'h11, q);
        for (int a = 8'h38; a <= 8'h44; a += 4) bus(1'b1, a[7:0], 32'h0);
        // Edge count: load 5, match 2, three edges
        bus(1'b1, 8'h28, 32'h5);
        bus(1'b1, 8'h30, 32'h2);
        bus(1'b1, 8'h04, 32'h2);
        bus(1'b1, 8'h18, 32'h2);
        bus(1'b1, 8'h0c, 32'h1);
        edges(2);
        bus(1'b0, 8'h1c, 32'h0);
        chk("match after two edges", 32'h0, q & 32'h2);
        chk("irq after two edges", 32'h0, {31'h0, irq});
        bus(1'b0, 8'h48, 32'h0);
        chk("A capture after two edges", 32'h4, q);
        edges(1);
        bus(1'b0, 8'h1c, 32'h0);
        chk("match after three edges", 32'h2, q & 32'h2);
        chk("irq after three edges", 32'h1, {31'h0, irq});
        bus(1'b1, 8'h18, 32'h0);
        @(negedge core_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, 8'h18, 32'h2);
        @(negedge core_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        bus(1'b1, 8'h1c, 32'h2);
        @(negedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // PWM on B: load 9, match 4, half the period high
        bus(1'b1, 8'h2c, 32'h9);
        bus(1'b1, 8'h34, 32'h4);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h0c, 32'h3);
        repeat (30) @(posedge core_clk);
        hi = 0;
        repeat (100) begin
            @(negedge core_clk);
            if (pwm_b === 1'b1) hi++;
        end
        chk("pwm_b high cycles", 32'd50, hi);
        // Second reset in mid-run
        @(posedge core_clk) rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        bus(1'b0, 8'h2c, 32'h0);
        chk("B load after reset", 32'h0000ffff, q);
        bus(1'b0, 8'h38, 32'h0);
        chk("A prescale after reset", 32'h0, q);
        // 32-bit RTC: both halves must agree before a match
        bus(1'b1, 8'h28, 32'h3);
        bus(1'b1, 8'h30, 32'h10001);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h0c, 32'h1);
        repeat (12) @(posedge core_clk);
        bus(1'b0, 8'h1c, 32'h0);
        chk("rtc with upper half off", 32'h0, q & 32'h8);
        bus(1'b1, 8'h30, 32'h1);
        repeat (12) @(posedge core_clk);
        bus(1'b0, 8'h1c, 32'h0);
        chk("rtc match", 32'h8, q & 32'h8);
        // B PWM with prescale 2: 24-bit match and divided period
        bus(1'b1, 8'h00, 32'h4);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h2c, 32'h9);
        bus(1'b1, 8'h34, 32'h4);
        bus(1'b1, 8'h3c, 32'h2);
        bus(1'b1, 8'h44, 32'h3);
        bus(1'b1, 8'h0c, 32'h2);
        repeat (40) @(posedge core_clk);
        bus(1'b0, 8'h1c, 32'h0);
        chk("prescale match never reached", 32'h0, q & 32'h200);
        bus(1'b1, 8'h44, 32'h1);
        repeat (40) @(posedge core_clk);
        bus(1'b0, 8'h1c, 32'h0);
        chk("prescale match", 32'h200, q & 32'h200);
        hi = 0;
        rise();
        hi = 0;
        rise();
        chk("pwm_b period", 32'd30, hi);
        complete_run();
    end
endmodule // gtm_regs_tb

bind gtm_regs gtm_regs_checker u_chk (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ccp_a_pin(ccp_a_pin), .ccp_b_pin(ccp_b_pin), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));
